// [core/can_mode_control.sv]
// Purpose: mode control/handshake register of a CAN controller
// Assumes: protocol engine sits outside and obeys the gating outputs
// Notes:   all outputs registered, one cycle behind their cause
`timescale 1ns/1ps
module can_mode_control
  import can_mode_pkg::*;
#(
  parameter int WAKE_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)
(
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [5:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       SYS_SPECIAL,
  input  wire logic       RX_BUSY,
  input  wire logic       TX_PENDING,
  input  wire logic       TX_DONE,
  input  wire logic       RX_DONE,
  input  wire logic       CORE_TX,
  input  wire logic       BUS_RX_PIN,
  output logic            BUS_TX_PIN,
  output logic            CORE_RX,
  output logic            MODULE_ON,
  output logic            PROTO_CLK_SEL,
  output logic            ACK_IGNORE,
  output logic            ACK_SEND_ALLOW,
  output logic            ERRFRAME_ALLOW,
  output logic            ERRCNT_FREEZE,
  output logic            TX_ALLOW,
  output logic            ABORT_XFER,
  output logic            IRQ
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_cfg(input logic [5:0] a);
    is_cfg = (a == OFS_TIMING_A) || (a == OFS_TIMING_B) || (a == OFS_ACC_CTL) ||
             ((a >= OFS_CODE_0) && (a <= OFS_MASK_LAST));
  endfunction

  function automatic logic [4:0] cfg_idx(input logic [5:0] a);
    logic [5:0] d;
    d = a - OFS_CODE_0;
    if (a == OFS_TIMING_A)
      cfg_idx = IDX_TIMING_A;
    else if (a == OFS_TIMING_B)
      cfg_idx = IDX_TIMING_B;
    else if (a == OFS_ACC_CTL)
      cfg_idx = IDX_ACC_CTL;
    else
      cfg_idx = IDX_CODE_0 + d[4:0];
  endfunction

  // ****************************************
  // state
  // ****************************************
  mode_state_e       state_ff;
  mode_state_e       nxt_state;
  mode_ctl_s         ctl_ff;
  logic              once_ff;
  logic              setup_req_ff;
  logic              sleep_req_ff;
  logic              wake_allow_ff;
  logic [7:0]        cfg_ff [CFG_N];
  logic [IRQ_N-1:0]  stat_ff;
  logic [IRQ_N-1:0]  mask_ff;
  logic              rx_s1_ff;
  logic              rx_s2_ff;
  logic              rx_s3_ff;
  logic              rx_ff;
  logic [15:0]       dom_cnt_ff;

  // ****************************************
  // decode
  // ****************************************
  wire setup_act = setup_req_ff && (state_ff == ST_SETUP);
  wire sleep_act = sleep_req_ff && (state_ff == ST_SLEEP);
  wire wr_prim   = WR && (ADDR == OFS_PRIMARY);
  wire wr_ctl    = WR && (ADDR == OFS_MODE_CTL) && setup_act;
  wire wr_cfg    = WR && is_cfg(ADDR) && setup_act;
  wire wr_stat   = WR && (ADDR == OFS_IRQ_STAT);
  wire wr_mask   = WR && (ADDR == OFS_IRQ_MASK);
  wire on_wr_ok  = SYS_SPECIAL || !once_ff;
  wire [4:0] widx = cfg_idx(ADDR);

  // write data seen through the register layout, so no bit index is spelled out
  mode_ctl_s wr_view;
  assign wr_view = WDATA;

  // wake detect: plain dominant level or dominant held for the filter time
  wire rx_dom    = !rx_ff;
  wire filt_hit  = rx_dom && (dom_cnt_ff >= 16'(WAKE_CYC - 1));
  wire wake_hit  = ctl_ff.wake_filter_select ? filt_hit : rx_dom;
  wire wake_go   = (state_ff == ST_SLEEP) && wake_allow_ff && wake_hit;
  wire bus_idle  = !RX_BUSY && !TX_PENDING;

  // next mode control value; bit 3 and the ack bits are never stored
  mode_ctl_s nxt_ctl;
  always_comb
  begin
    nxt_ctl = ctl_ff;
    if (wr_ctl)
    begin
      if (on_wr_ok)
        nxt_ctl.module_on = wr_view.module_on;
      nxt_ctl.protocol_clock_select = wr_view.protocol_clock_select;
      nxt_ctl.internal_echo_test    = wr_view.internal_echo_test;
      nxt_ctl.listen_only           = wr_view.listen_only;
      nxt_ctl.wake_filter_select    = wr_view.wake_filter_select;
    end
    nxt_ctl.unused_3       = 1'b0;
    nxt_ctl.sleep_ack      = 1'b0;
    nxt_ctl.setup_mode_ack = 1'b0;
  end

  // primary request bits; cpu may drop a request only once acknowledged
  wire nxt_setup_req = wr_prim ? (WDATA[BIT_SETUP_REQ] || (setup_req_ff && state_ff != ST_SETUP))
                               : setup_req_ff;
  wire sleep_wr      = wr_prim ? (WDATA[BIT_SLEEP_REQ] || (sleep_req_ff && state_ff != ST_SLEEP))
                               : sleep_req_ff;
  wire nxt_sleep_req = wake_go ? 1'b0 : sleep_wr;

  // ****************************************
  // handshake state machine
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:
        if (setup_req_ff)
          nxt_state = ST_ABORT;
        else if (sleep_req_ff && bus_idle)
          nxt_state = ST_SLEEP;
      ST_ABORT:
        nxt_state = ST_SETUP;
      ST_SETUP:
        if (!setup_req_ff)
          nxt_state = ST_RUN;
      ST_SLEEP:
        if (setup_req_ff)
          nxt_state = ST_ABORT;
        else if (!sleep_req_ff || wake_go)
          nxt_state = ST_RUN;
      default:
        nxt_state = ST_SETUP;
    endcase
  end

  // sticky events, set wins over write-one clear
  wire [IRQ_N-1:0] ev;
  assign ev[IRQ_TX_DONE] = TX_DONE;
  assign ev[IRQ_RX_DONE] = RX_DONE;
  assign ev[IRQ_WAKE]    = wake_go;
  assign ev[IRQ_SETUP]   = (state_ff == ST_ABORT);
  wire [IRQ_N-1:0] nxt_stat = (stat_ff & ~(wr_stat ? WDATA[IRQ_N-1:0] : '0)) | ev;

  // read mux, unmapped addresses read zero
  mode_ctl_s rd_ctl;
  always_comb
  begin
    rd_ctl                = ctl_ff;
    rd_ctl.unused_3       = 1'b0;
    rd_ctl.sleep_ack      = (state_ff == ST_SLEEP);
    rd_ctl.setup_mode_ack = (state_ff == ST_SETUP);
  end
  wire [7:0] prim_rd = {5'h00, wake_allow_ff, sleep_req_ff, setup_req_ff};
  wire [7:0] nxt_rdata = !RD                    ? 8'h00 :
                         (ADDR == OFS_PRIMARY)  ? prim_rd :
                         (ADDR == OFS_MODE_CTL) ? rd_ctl :
                         is_cfg(ADDR)           ? cfg_ff[widx] :
                         (ADDR == OFS_IRQ_STAT) ? {{(8-IRQ_N){1'b0}}, stat_ff} :
                         (ADDR == OFS_IRQ_MASK) ? {{(8-IRQ_N){1'b0}}, mask_ff} : 8'h00;

  // pin side: echo, listen and disable keep the line recessive
  wire tx_quiet   = ctl_ff.internal_echo_test || ctl_ff.listen_only || !ctl_ff.module_on ||
                    (state_ff != ST_RUN) || setup_req_ff;
  wire nxt_tx_pin = tx_quiet ? RECESSIVE : CORE_TX;
  wire nxt_rx     = ctl_ff.internal_echo_test ? CORE_TX : rx_ff;

  // ****************************************
  // registers
  // ****************************************
  // control and handshake
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_ff      <= ST_SETUP;
      ctl_ff        <= RST_MODE_CTL;
      once_ff       <= 1'b0;
      setup_req_ff  <= RST_SETUP;
      sleep_req_ff  <= 1'b0;
      wake_allow_ff <= 1'b0;
      stat_ff       <= '0;
      mask_ff       <= '0;
    end
    else
    begin
      state_ff      <= nxt_state;
      ctl_ff        <= nxt_ctl;
      once_ff       <= once_ff || wr_ctl;
      setup_req_ff  <= nxt_setup_req;
      sleep_req_ff  <= nxt_sleep_req;
      wake_allow_ff <= wr_prim ? WDATA[BIT_WAKE_ALLOW] : wake_allow_ff;
      stat_ff       <= nxt_stat;
      mask_ff       <= wr_mask ? WDATA[IRQ_N-1:0] : mask_ff;
    end
  end

  // timing and acceptance storage, setup mode writes only
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      for (int i = 0; i < CFG_N; i++)
        cfg_ff[i] <= RST_CFG;
    else if (wr_cfg)
      cfg_ff[widx] <= WDATA;
  end

  // rx pin: three flops, accept once stages two and three agree
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_s1_ff <= RECESSIVE;
      rx_s2_ff <= RECESSIVE;
      rx_s3_ff <= RECESSIVE;
      rx_ff    <= RECESSIVE;
    end
    else
    begin
      rx_s1_ff <= BUS_RX_PIN;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      rx_ff    <= (rx_s2_ff == rx_s3_ff) ? rx_s3_ff : rx_ff;
    end
  end

  // dominant length counter for the wake filter; saturates, not wraps
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      dom_cnt_ff <= 16'h0000;
    else if (!rx_dom)
      dom_cnt_ff <= 16'h0000;
    else if (dom_cnt_ff != 16'hFFFF)
      dom_cnt_ff <= dom_cnt_ff + 16'h0001;
  end

  // registered outputs
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RDATA          <= 8'h00;
      BUS_TX_PIN     <= RECESSIVE;
      CORE_RX        <= RECESSIVE;
      MODULE_ON      <= 1'b0;
      PROTO_CLK_SEL  <= 1'b0;
      ACK_IGNORE     <= 1'b0;
      ACK_SEND_ALLOW <= 1'b0;
      ERRFRAME_ALLOW <= 1'b0;
      ERRCNT_FREEZE  <= 1'b0;
      TX_ALLOW       <= 1'b0;
      ABORT_XFER     <= 1'b0;
      IRQ            <= 1'b0;
    end
    else
    begin
      RDATA          <= nxt_rdata;
      BUS_TX_PIN     <= nxt_tx_pin;
      CORE_RX        <= nxt_rx;
      MODULE_ON      <= ctl_ff.module_on;
      PROTO_CLK_SEL  <= ctl_ff.protocol_clock_select;
      ACK_IGNORE     <= ctl_ff.internal_echo_test;
      ACK_SEND_ALLOW <= !ctl_ff.listen_only;
      ERRFRAME_ALLOW <= !ctl_ff.listen_only;
      ERRCNT_FREEZE  <= ctl_ff.listen_only || setup_act;
      TX_ALLOW       <= !ctl_ff.listen_only && ctl_ff.module_on && (state_ff == ST_RUN);
      ABORT_XFER     <= (nxt_state == ST_ABORT);
      IRQ            <= |(nxt_stat & mask_ff);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_ctl_guard;
    @(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == OFS_MODE_CTL && !setup_act) |=> $stable(ctl_ff);
  endproperty
  a_ctl_guard: assert property (p_ctl_guard) else $error("mode control changed outside setup");

  property p_once;
    @(posedge CLK) disable iff (!RSTN)
    (once_ff && !SYS_SPECIAL) |=> $stable(ctl_ff.module_on);
  endproperty
  a_once: assert property (p_once) else $error("module enable rewritten in normal mode");

  property p_enable;
    @(posedge CLK) disable iff (!RSTN)
    (wr_ctl && on_wr_ok) |=> ##1 (MODULE_ON == $past(wr_view.module_on, 2));
  endproperty
  a_enable: assert property (p_enable) else $error("enable output does not follow bit 7");

  property p_clksel;
    @(posedge CLK) disable iff (!RSTN)
    wr_ctl |=> ##1 (PROTO_CLK_SEL == $past(wr_view.protocol_clock_select, 2));
  endproperty
  a_clksel: assert property (p_clksel) else $error("clock select does not follow bit 6");

  property p_echo;
    @(posedge CLK) disable iff (!RSTN)
    ctl_ff.internal_echo_test |=> (BUS_TX_PIN == RECESSIVE) && (CORE_RX == $past(CORE_TX));
  endproperty
  a_echo: assert property (p_echo) else $error("loopback leaks to pin or loses echo");

  property p_listen;
    @(posedge CLK) disable iff (!RSTN)
    ctl_ff.listen_only |=> !TX_ALLOW && !ACK_SEND_ALLOW && !ERRFRAME_ALLOW && ERRCNT_FREEZE;
  endproperty
  a_listen: assert property (p_listen) else $error("listen mode still active on bus");

  property p_sleep_idle;
    @(posedge CLK) disable iff (!RSTN)
    (state_ff == ST_RUN && !setup_req_ff && sleep_req_ff && !bus_idle) |=> (state_ff != ST_SLEEP);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep entered with bus busy");

  property p_wake;
    @(posedge CLK) disable iff (!RSTN)
    (wake_go && !setup_req_ff) |=> (state_ff == ST_RUN) && !sleep_req_ff;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not clear sleep");

  property p_abort;
    @(posedge CLK) disable iff (!RSTN)
    $rose(state_ff == ST_SETUP) |-> $past(ABORT_XFER);
  endproperty
  a_abort: assert property (p_abort) else $error("setup acknowledged without abort");

  property p_cfg_guard;
    @(posedge CLK) disable iff (!RSTN)
    (WR && is_cfg(ADDR) && !setup_act) |=> (cfg_ff[$past(widx)] == $past(cfg_ff[widx]));
  endproperty
  a_cfg_guard: assert property (p_cfg_guard) else $error("config written outside setup");

endmodule

// [core/can_mode_pkg.sv]
// Purpose: constants and types for the CAN mode control register block
// Assumes: 8-bit register port, 100 MHz CLK, one clock domain
// Notes:   byte offsets below are register addresses on the plain port
package can_mode_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] OFS_PRIMARY   = 6'h00;
  localparam logic [5:0] OFS_MODE_CTL  = 6'h01;
  localparam logic [5:0] OFS_TIMING_A  = 6'h02;
  localparam logic [5:0] OFS_TIMING_B  = 6'h03;
  localparam logic [5:0] OFS_ACC_CTL   = 6'h0B;
  localparam logic [5:0] OFS_CODE_0    = 6'h10;
  localparam logic [5:0] OFS_MASK_0    = 6'h18;
  localparam logic [5:0] OFS_MASK_LAST = 6'h1F;
  localparam logic [5:0] OFS_IRQ_STAT  = 6'h20;
  localparam logic [5:0] OFS_IRQ_MASK  = 6'h21;

  // config storage indices
  localparam int         CFG_N        = 19;
  localparam logic [4:0] IDX_TIMING_A = 5'h00;
  localparam logic [4:0] IDX_TIMING_B = 5'h01;
  localparam logic [4:0] IDX_ACC_CTL  = 5'h02;
  localparam logic [4:0] IDX_CODE_0   = 5'h03;

  // primary control bit positions
  localparam int BIT_SETUP_REQ  = 0;
  localparam int BIT_SLEEP_REQ  = 1;
  localparam int BIT_WAKE_ALLOW = 2;

  // interrupt status bit positions
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_WAKE    = 2;
  localparam int IRQ_SETUP   = 3;
  localparam int IRQ_N       = 4;

  // reset values
  localparam logic [7:0] RST_MODE_CTL = 8'h00;
  localparam logic [7:0] RST_CFG      = 8'h00;
  localparam logic       RST_SETUP    = 1'b1;
  localparam logic       RECESSIVE    = 1'b1;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_FILT_NS  = 2000;

  // mode control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic module_on;
    logic protocol_clock_select;
    logic internal_echo_test;
    logic listen_only;
    logic unused_3;
    logic wake_filter_select;
    logic sleep_ack;
    logic setup_mode_ack;
  } mode_ctl_s;

  // handshake states
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_ABORT = 4'b0010,
    ST_SETUP = 4'b0100,
    ST_SLEEP = 4'b1000
  } mode_state_e;

endpackage

// [dv/can_bus_node.sv]
// Purpose: transceiver plus remote nodes on a wired-and bus
// Assumes: 1 is recessive, 0 dominant
// Notes:   remote_dom lets the bench pull the bus dominant
`timescale 1ns/1ps
module can_bus_node
(
  input  wire logic tx_pin,
  input  wire logic remote_dom,
  output logic      rx_pin
);
  // ****************************************
  // bus level
  // ****************************************
  // dominant wins, so our own recessive never masks a remote node
  assign rx_pin = tx_pin & ~remote_dom;
endmodule

// [dv/can_mode_control_register_tb.sv]
// Purpose: self-checking bench for the mode control register block
// Assumes: WAKE_CYC shortened to 4 cycles
// Notes:   outs packs seven gating outputs plus the tx pin for one compare
`timescale 1ns/1ps
module can_mode_control_register_tb
  import can_mode_pkg::*;
;
  logic       clk = 0, rstn = 0, wr_s = 0, rd_s = 0, special = 0;
  logic       rx_busy = 0, tx_pend = 0, tx_done = 0, rx_done = 0, core_tx = 1, dom = 0;
  logic [5:0] addr = 0;
  logic [7:0] wdata = 0, rdata, v;
  logic       rx_pin, tx_pin, core_rx, mod_on, clk_sel, ack_ign, ack_send, errf, frz, tx_allow, abort, irq;
  int         mismatches = 0;
  int         tests_run = 0;
  wire  [7:0] outs = {mod_on, clk_sel, ack_ign, ack_send, errf, frz, tx_allow, tx_pin};

  always #5 clk = ~clk;

  can_mode_control #(.WAKE_CYC(4)) dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .SYS_SPECIAL(special), .RX_BUSY(rx_busy), .TX_PENDING(tx_pend),
    .TX_DONE(tx_done), .RX_DONE(rx_done), .CORE_TX(core_tx), .BUS_RX_PIN(rx_pin), .BUS_TX_PIN(tx_pin),
    .CORE_RX(core_rx), .MODULE_ON(mod_on), .PROTO_CLK_SEL(clk_sel), .ACK_IGNORE(ack_ign),
    .ACK_SEND_ALLOW(ack_send), .ERRFRAME_ALLOW(errf), .ERRCNT_FREEZE(frz), .TX_ALLOW(tx_allow),
    .ABORT_XFER(abort), .IRQ(irq));
  can_bus_node node (.tx_pin(tx_pin), .remote_dom(dom), .rx_pin(rx_pin));

  // ****************************************
  // bus cycles and compares
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    // taken at the next edge, before that edge replaces it
    @(posedge clk);
    v = rdata;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask
  // bounded wait on a handshake bit
  task automatic poll(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    do
    begin
      rd(a);
      n++;
    end
    while (((v & m) !== e) && n < 40);
    chk(v & m, e);
  endtask
  task automatic wait_chk(input int n, input logic [7:0] got_sel, input logic [7:0] e);
    repeat (n) @(posedge clk);
    chk(got_sel == 8'h01 ? outs : {6'h00, tx_pin, core_rx}, e);
  endtask
  task automatic set_mode(input logic [7:0] m);
    wr(OFS_PRIMARY, 8'h01);
    poll(OFS_MODE_CTL, 8'h01, 8'h01);
    wr(OFS_MODE_CTL, m);
    wr(OFS_PRIMARY, 8'h00);
    poll(OFS_MODE_CTL, 8'h01, 8'h00);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdc(OFS_MODE_CTL, 8'h01);
    rdc(OFS_TIMING_A, RST_CFG);
    rdc(6'h3F, 8'h00);
    chk(outs, 8'h1D);
  endtask
  task automatic t_enable_once;
    wr(OFS_MODE_CTL, 8'hFF);
    rdc(OFS_MODE_CTL, 8'hF5);
    chk(outs, 8'hE5);
    wr(OFS_MODE_CTL, 8'h00);
    rdc(OFS_MODE_CTL, 8'h81);
    special <= 1'b1;
    wr(OFS_MODE_CTL, 8'h40);
    rdc(OFS_MODE_CTL, 8'h41);
    special <= 1'b0;
    wr(OFS_MODE_CTL, 8'h80);
    rdc(OFS_MODE_CTL, 8'h01);
    special <= 1'b1;
    wr(OFS_MODE_CTL, 8'h80);
    special <= 1'b0;
  endtask
  // config and control writes only land in setup mode
  task automatic t_cfg;
    wr(OFS_TIMING_A, 8'h5A);
    wr(OFS_MASK_LAST, 8'hC3);
    wr(OFS_PRIMARY, 8'h00);
    poll(OFS_MODE_CTL, 8'h01, 8'h00);
    wr(OFS_TIMING_A, 8'hA5);
    wr(OFS_MASK_LAST, 8'h3C);
    wr(OFS_MODE_CTL, 8'hC0);
    rdc(OFS_TIMING_A, 8'h5A);
    rdc(OFS_MASK_LAST, 8'hC3);
    rdc(OFS_MODE_CTL, 8'h80);
    chk(outs, 8'h9B);
  endtask
  task automatic t_modes;
    logic [7:0] mt [4] = '{8'h80, 8'hC0, 8'hA0, 8'h90};
    logic [7:0] et [4] = '{8'h9A, 8'hDA, 8'hBB, 8'h85};
    core_tx <= 1'b0;
    foreach (mt[i])
    begin
      set_mode(mt[i]);
      wait_chk(3, 8'h01, et[i]);
    end
    set_mode(8'hA0);
    dom <= 1'b1;
    wait_chk(3, 8'h00, 8'h02);
    core_tx <= 1'b1;
    wait_chk(3, 8'h00, 8'h03);
    set_mode(8'h80);
    dom <= 1'b0;
    core_tx <= 1'b0;
    wait_chk(8, 8'h00, 8'h00);
    dom <= 1'b1;
    core_tx <= 1'b1;
    wait_chk(8, 8'h00, 8'h02);
    dom <= 1'b0;
  endtask
  task automatic t_abort;
    int n;
    n = 0;
    core_tx <= 1'b0;
    wr(OFS_PRIMARY, 8'h01);
    while (abort !== 1'b1 && n < 6)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, abort}, 8'h01);
    chk({7'h00, tx_pin}, 8'h01);
    poll(OFS_MODE_CTL, 8'h01, 8'h01);
    core_tx <= 1'b1;
  endtask
  // loopback traffic still raises both interrupt sources
  task automatic t_irq;
    set_mode(8'hA0);
    wr(OFS_IRQ_STAT, 8'h0F);
    wr(OFS_IRQ_MASK, 8'h03);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    rdc(OFS_IRQ_STAT, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_MASK, 8'h02);
    wait_chk(2, 8'h01, 8'hBB);
    chk({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_STAT, 8'h01);
    rdc(OFS_IRQ_STAT, 8'h00);
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
    rdc(OFS_IRQ_STAT, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_STAT, 8'h02);
    rdc(OFS_IRQ_MASK, 8'h02);
    chk({7'h00, irq}, 8'h00);
  endtask
  // mode control value in force while sleep is tried
  logic [7:0] mt_mode = 8'h84;
  task automatic sleep_try(input logic [7:0] prim, input int len, input logic wake);
    wr(OFS_PRIMARY, prim);
    poll(OFS_MODE_CTL, 8'h02, 8'h02);
    dom <= 1'b1;
    repeat (len) @(posedge clk);
    dom <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(OFS_MODE_CTL, wake ? mt_mode : (mt_mode | 8'h02));
    rdc(OFS_PRIMARY, wake ? prim & 8'h04 : prim);
    wr(OFS_PRIMARY, 8'h00);
    poll(OFS_MODE_CTL, 8'h02, 8'h00);
  endtask
  task automatic t_sleep;
    set_mode(8'h84);
    rx_busy <= 1'b1;
    tx_pend <= 1'b1;
    wr(OFS_PRIMARY, 8'h06);
    rx_busy <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(OFS_MODE_CTL, 8'h84);
    tx_pend <= 1'b0;
    sleep_try(8'h06, 2, 1'b0);
    sleep_try(8'h06, 12, 1'b1);
    sleep_try(8'h02, 12, 1'b0);
    mt_mode = 8'h80;
    set_mode(8'h80);
    sleep_try(8'h06, 6, 1'b1);
  endtask

  // ****************************************
  // verdict and sequencing
  // ****************************************
  task automatic close_out;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // whole run is well under a thousand cycles, so 20k is a clear hang
  initial
  begin
    #200000;
    mismatches++;
    close_out;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_enable_once;
    t_cfg;
    t_modes;
    t_abort;
    t_irq;
    t_sleep;
    close_out;
  end
endmodule
